// ===== design/flash_rd_consts.svh
// Purpose: constants of the serial flash read engine
// Assumes: included by its bare name from the design files
// Notes: counts are in link clock edges unless named otherwise
// Function
// RULE1 - single read: opcode, address in, data out
// RULE2 - address advances per byte, wraps to zero
// RULE3 - fast read adds one dummy byte
// RULE4 - busy device ignores fast and multi-line reads
// RULE5 - four-line mode fast read, dummy 4/6/8
// RULE6 - dual output: dummy byte, two-bit data
// RULE7 - two-line address, dummy and data
// RULE8 - mode bits 10 skip the next opcode
// RULE9 - other mode bits or reset leave continuous
// RULE10 - host sends non-10 mode bits by default
// RULE11 - host sets quad enable before quad read
// RULE12 - quad output: dummy byte, four-bit data
// RULE13 - chip select high stops output at once
// RULE14 - quad transfers only with quad enable set; four-line mode fast read is accepted without it
// RULE15 - plain read is 03h; idle lines high-z
// RULE16 - mode byte counts as dummy, bits latched
`ifndef FLASH_RD_CONSTS_SVH
`define FLASH_RD_CONSTS_SVH

// ****************************************
// opcodes
// ****************************************
`define OP_READ 8'h03
`define OP_FAST 8'h0b
`define OP_DUAL 8'h3b
`define OP_TWO_ADDR 8'hbb
`define OP_QUAD 8'h6b

// ****************************************
// phase lengths and mode bits
// ****************************************
`define OP_BITS 5'h08
`define ADDR_BITS 5'h18
`define DUMMY_CLKS 5'h08
`define TWO_ADDR_DUMMY 5'h04
`define QPI_DUMMY_P0 5'h04
`define QPI_DUMMY_P1 5'h06
`define QPI_DUMMY_P2 5'h08
`define BYTE_BITS 4'h8
`define MODE_HOLD 2'h2

// ****************************************
// pin drive, reset values and top address
// ****************************************
`define OE_OFF 4'hf
`define OE_ONE 4'hd
`define OE_TWO 4'hc
`define OE_FOUR 4'h0
`define SYNC_RST 6'h20
`define ADDR_TOP 24'hffffff

`endif

// ===== design/flash_rd_pkg.sv
// Purpose: types and helpers of the serial flash read engine
// Assumes: nothing beyond the constants header
// Notes: shift helper takes bits msb first
package flash_rd_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD = 3'h1,
        ST_ADDR = 3'h3,
        ST_DUMMY = 3'h2,
        ST_DATA = 3'h6,
        ST_IGNORE = 3'h7
    } rd_state_t;

    typedef enum logic [1:0] {LN_1 = 2'h0, LN_2 = 2'h1, LN_4 = 2'h2} lanes_t;

    function automatic logic [4:0] clks(input logic [4:0] bits,
                                        input lanes_t ln);
        case (ln)
            LN_2: clks = bits >> 1;
            LN_4: clks = bits >> 2;
            default: clks = bits;
        endcase
    endfunction

    function automatic logic [23:0] shin(input logic [23:0] v,
                                         input logic [3:0] io,
                                         input lanes_t ln);
        case (ln)
            LN_2: shin = {v[21:0], io[1:0]};
            LN_4: shin = {v[19:0], io};
            default: shin = {v[22:0], io[0]};
        endcase
    endfunction
endpackage

// ===== design/link_if.sv
// Purpose: synchronised link signals between engine modules
// Assumes: all members are on clk_i
// Notes: edges are valid only while chip select is low
`timescale 1ns/1ps
`default_nettype none
interface link_if;
    logic cs_n;
    logic cs_fall;
    logic rise;
    logic fall;
    logic [3:0] io;
    modport src(output cs_n, cs_fall, rise, fall, io);
    modport dst(input cs_n, cs_fall, rise, fall, io);
endinterface
`default_nettype wire

// ===== design/link_sync.sv
// Purpose: two-stage synchroniser and edge finder for the link pins
// Assumes: link clock half period spans several clk_i cycles
// Notes: only the second stage feeds any logic
`timescale 1ns/1ps
`default_nettype none
`include "flash_rd_consts.svh"
module link_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [3:0] io_i,
    link_if.src link
);
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic [1:0] prev_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= `SYNC_RST;
            sync_q <= `SYNC_RST;
            prev_q <= 2'h2;
        end else begin
            meta_q <= {cs_n_i, sclk_i, io_i};
            sync_q <= meta_q;
            prev_q <= sync_q[5:4];
        end
    end

    // edges gated by chip select so stray clocks do nothing
    assign link.cs_n = sync_q[5];
    assign link.cs_fall = !sync_q[5] && prev_q[1];
    assign link.rise = !sync_q[5] && sync_q[4] && !prev_q[0];
    assign link.fall = !sync_q[5] && !sync_q[4] && prev_q[0];
    assign link.io = sync_q[3:0];
endmodule // link_sync
`default_nettype wire

// ===== design/byte_shifter.sv
// Purpose: serialises a data byte onto one, two or four lines
// Assumes: a new byte is loaded before the next falling edge
// Notes: stop has priority so output ends mid byte
`timescale 1ns/1ps
`default_nettype none
`include "flash_rd_consts.svh"
module byte_shifter
    import flash_rd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [7:0] data_i,
    input wire logic shift_i,
    input wire logic stop_i,
    input wire lanes_t lanes_i,
    output logic [3:0] io_o,
    output logic [3:0] oe_n_o,
    output logic last_o
);
    logic [7:0] sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d, io_q, io_d, oe_q, oe_d, step;

    always_comb begin
        case (lanes_i)
            LN_2: step = 4'h2;
            LN_4: step = 4'h4;
            default: step = 4'h1;
        endcase
        last_o = shift_i && (cnt_q == step);
        sh_d = sh_q;
        cnt_d = cnt_q;
        io_d = io_q;
        oe_d = oe_q;
        // RULE13 stop at once
        if (stop_i) begin
            oe_d = `OE_OFF;
        end else if (shift_i && cnt_q != 4'h0) begin
            // RULE6 msb first
            case (lanes_i)
                LN_2: begin
                    io_d = {2'h0, sh_q[7:6]};
                    oe_d = `OE_TWO;
                end
                LN_4: begin
                    io_d = sh_q[7:4];
                    oe_d = `OE_FOUR;
                end
                default: begin
                    io_d = {2'h0, sh_q[7], 1'b0};
                    oe_d = `OE_ONE;
                end
            endcase
            sh_d = sh_q << step;
            cnt_d = cnt_q - step;
        end
        if (load_i) begin
            sh_d = data_i;
            cnt_d = `BYTE_BITS;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            io_q <= 4'h0;
            oe_q <= `OE_OFF;
        end else begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            io_q <= io_d;
            oe_q <= oe_d;
        end
    end

    assign io_o = io_q;
    assign oe_n_o = oe_q;
endmodule // byte_shifter
`default_nettype wire

// ===== design/serial_flash_read_engine.sv
// Purpose: read-command front end of a serial flash, pin side
// Assumes: link pins asynchronous to clk_i; memory answers a cycle late
// Notes: link clock half period must span four or more clk_i cycles
`timescale 1ns/1ps
`default_nettype none
`include "flash_rd_consts.svh"
module serial_flash_read_engine
    import flash_rd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic [3:0] io_oe_n_o,
    input wire logic busy_i,
    input wire logic quad_enable_bit_i,
    input wire logic four_line_instruction_mode_i,
    input wire logic [1:0] read_param_i,
    input wire logic cont_read_reset_i,
    input wire logic [7:0] mem_data_i,
    output logic mem_rd_o,
    output logic [23:0] mem_addr_o,
    output logic cont_read_o,
    output logic reject_o
);
    link_if link ();
    rd_state_t state_q, state_d;
    logic [7:0] op_q, op_d, opn;
    logic [23:0] addr_q, addr_d, tmp;
    logic [4:0] cnt_q, cnt_d, dum_q, dum_d, dec_dum, drise_q;
    lanes_t ln_q, ln_d, dln_q, dln_d, dec_aln, dec_dln;
    logic cont_q, cont_d, rd_q, rd_d, ld_q, rej_q, rej_d;
    logic dec_ok, last, shift, cap, four_line_instruction_mode;

    link_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .cs_n_i(spi_cs_n_i),
        .sclk_i(spi_sclk_i),
        .io_i(io_i),
        .link(link)
    );

    assign shift = (state_q == ST_DATA) && link.fall;
    assign four_line_instruction_mode = four_line_instruction_mode_i;
    assign cap = (state_q == ST_DUMMY) && link.rise && !link.cs_n
                 && (op_q == `OP_TWO_ADDR) && (cnt_q == dum_q - 5'h01);

    byte_shifter u_shift (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(ld_q),
        .data_i(mem_data_i),
        .shift_i(shift),
        .stop_i(link.cs_n),
        .lanes_i(dln_q),
        .io_o(io_o),
        .oe_n_o(io_oe_n_o),
        .last_o(last)
    );

    // ****************************************
    // opcode decode
    // ****************************************
    always_comb begin
        tmp = shin({16'h0000, op_q}, link.io, ln_q);
        opn = tmp[7:0];
        dec_ok = 1'b1;
        dec_aln = LN_1;
        dec_dln = LN_1;
        dec_dum = `DUMMY_CLKS;
        if (four_line_instruction_mode) begin
            dec_aln = LN_4;
            dec_dln = LN_4;
            dec_ok = (opn == `OP_FAST);
            // RULE5 dummy by parameter
            case (read_param_i)
                2'h0: dec_dum = `QPI_DUMMY_P0;
                2'h1: dec_dum = `QPI_DUMMY_P1;
                default: dec_dum = `QPI_DUMMY_P2;
            endcase
        end else begin
            case (opn)
                // RULE15 plain read code
                `OP_READ: dec_dum = 5'h00;
                // RULE3 one dummy byte
                `OP_FAST: dec_dum = `DUMMY_CLKS;
                // RULE6 two-line data
                `OP_DUAL: dec_dln = LN_2;
                // RULE7 two-line address
                `OP_TWO_ADDR: begin
                    dec_aln = LN_2;
                    dec_dln = LN_2;
                    dec_dum = `TWO_ADDR_DUMMY;
                end
                // RULE12 four-line data
                `OP_QUAD: begin
                    dec_dln = LN_4;
                    // RULE14 quad needs enable
                    dec_ok = quad_enable_bit_i;
                end
                default: dec_ok = 1'b0;
            endcase
        end
        // RULE4 busy rejects all but single-line plain read
        if (busy_i && (four_line_instruction_mode || opn != `OP_READ)) begin
            dec_ok = 1'b0;
        end
    end

    // ****************************************
    // command sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        addr_d = addr_q;
        cnt_d = cnt_q;
        dum_d = dum_q;
        ln_d = ln_q;
        dln_d = dln_q;
        rd_d = 1'b0;
        rej_d = 1'b0;
        cont_d = cont_q;
        // RULE9 mode reset clears
        if (cont_read_reset_i) begin
            cont_d = 1'b0;
        end
        // RULE2 advance after fetch
        if (rd_q) begin
            addr_d = addr_q + 24'h000001;
        end
        // RULE13 abort on deselect
        if (link.cs_n) begin
            state_d = ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (link.cs_fall && cont_q) begin
                        // RULE8 opcode skipped
                        state_d = busy_i ? ST_IGNORE : ST_ADDR;
                        rej_d = busy_i;
                        op_d = `OP_TWO_ADDR;
                        ln_d = LN_2;
                        dln_d = LN_2;
                        dum_d = `TWO_ADDR_DUMMY;
                        cnt_d = clks(`ADDR_BITS, LN_2);
                    end else if (link.cs_fall) begin
                        state_d = ST_CMD;
                        ln_d = four_line_instruction_mode ? LN_4 : LN_1;
                        cnt_d = clks(`OP_BITS, four_line_instruction_mode ? LN_4 : LN_1);
                    end
                end
                ST_CMD: begin
                    if (link.rise) begin
                        op_d = opn;
                        cnt_d = cnt_q - 5'h01;
                        if (cnt_q == 5'h01 && dec_ok) begin
                            state_d = ST_ADDR;
                            ln_d = dec_aln;
                            dln_d = dec_dln;
                            dum_d = dec_dum;
                            cnt_d = clks(`ADDR_BITS, dec_aln);
                        end else if (cnt_q == 5'h01) begin
                            state_d = ST_IGNORE;
                            rej_d = 1'b1;
                        end
                    end
                end
                ST_ADDR: begin
                    if (link.rise) begin
                        // RULE1 address on rising edge
                        addr_d = shin(addr_q, link.io, ln_q);
                        cnt_d = cnt_q - 5'h01;
                        if (cnt_q == 5'h01) begin
                            state_d = (dum_q == 5'h00) ? ST_DATA : ST_DUMMY;
                            rd_d = (dum_q == 5'h00);
                            cnt_d = dum_q;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (link.rise) begin
                        cnt_d = cnt_q - 5'h01;
                        // RULE16 mode byte in dummy
                        if (cap) begin
                            cont_d = (link.io[1:0] == `MODE_HOLD);
                        end
                        if (cnt_q == 5'h01) begin
                            state_d = ST_DATA;
                            rd_d = 1'b1;
                        end
                    end
                end
                ST_DATA: rd_d = last;
                ST_IGNORE: state_d = ST_IGNORE;
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            op_q <= 8'h00;
            addr_q <= 24'h000000;
            cnt_q <= 5'h00;
            dum_q <= 5'h00;
            ln_q <= LN_1;
            dln_q <= LN_1;
            rd_q <= 1'b0;
            ld_q <= 1'b0;
            rej_q <= 1'b0;
            cont_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            addr_q <= addr_d;
            cnt_q <= cnt_d;
            dum_q <= dum_d;
            ln_q <= ln_d;
            dln_q <= dln_d;
            rd_q <= rd_d;
            ld_q <= rd_q;
            rej_q <= rej_d;
            cont_q <= cont_d;
        end
    end

    assign mem_rd_o = rd_q;
    assign mem_addr_o = addr_q;
    assign cont_read_o = cont_q;
    assign reject_o = rej_q;

    // ****************************************
    // checks
    // ****************************************
    // helper: rising edges seen in the dummy phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drise_q <= 5'h00;
        end else if (state_q == ST_ADDR) begin
            drise_q <= 5'h00;
        end else if (state_q == ST_DUMMY && link.rise) begin
            drise_q <= drise_q + 5'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence op_end_s;
        state_q == ST_CMD && link.rise && !link.cs_n && cnt_q == 5'h01;
    endsequence
    sequence data_entry_s;
        $past(state_q) == ST_DUMMY && state_q == ST_DATA;
    endsequence

    addr_wrap_a: assert property ( // RULE2
        mem_rd_o && mem_addr_o == `ADDR_TOP |=> mem_addr_o == 24'h000000)
        else $error("address did not wrap to zero");
    addr_step_a: assert property ( // RULE2
        mem_rd_o && mem_addr_o != `ADDR_TOP
        |=> mem_addr_o == $past(mem_addr_o) + 24'h000001)
        else $error("address did not advance");
    busy_reject_a: assert property ( // RULE4
        op_end_s and (busy_i && opn != `OP_READ)
        |=> state_q == ST_IGNORE && reject_o)
        else $error("read accepted while busy");
    quad_gate_a: assert property ( // RULE14
        op_end_s and (opn == `OP_QUAD && !four_line_instruction_mode && !quad_enable_bit_i)
        |=> state_q == ST_IGNORE)
        else $error("quad read without quad enable");
    deselect_stop_a: assert property ( // RULE13
        link.cs_n |=> io_oe_n_o == `OE_OFF)
        else $error("output still driven after deselect");
    idle_hiz_a: assert property ( // RULE15
        state_q inside {ST_CMD, ST_ADDR, ST_DUMMY} |-> io_oe_n_o == `OE_OFF)
        else $error("line driven before data phase");
    fast_dummy_a: assert property ( // RULE3
        data_entry_s and (op_q == `OP_FAST && !four_line_instruction_mode)
        |-> drise_q == `DUMMY_CLKS)
        else $error("fast read dummy count wrong");
    qpi_dummy_a: assert property ( // RULE5
        data_entry_s and four_line_instruction_mode |-> drise_q == (read_param_i == 2'h0 ?
        `QPI_DUMMY_P0 : read_param_i == 2'h1 ? `QPI_DUMMY_P1 : `QPI_DUMMY_P2))
        else $error("four-line dummy count wrong");
    single_lane_a: assert property ( // RULE1
        state_q == ST_DATA && op_q == `OP_READ
        |-> io_oe_n_o inside {`OE_OFF, `OE_ONE})
        else $error("plain read used wrong lines");
    dual_lane_a: assert property ( // RULE6
        state_q == ST_DATA && op_q == `OP_DUAL
        |-> io_oe_n_o inside {`OE_OFF, `OE_TWO})
        else $error("dual read used wrong lines");
    two_addr_lane_a: assert property ( // RULE7
        state_q == ST_DATA && op_q == `OP_TWO_ADDR
        |-> io_oe_n_o inside {`OE_OFF, `OE_TWO})
        else $error("two-line read used wrong lines");
    quad_lane_a: assert property ( // RULE12
        state_q == ST_DATA && op_q == `OP_QUAD && !four_line_instruction_mode
        |-> io_oe_n_o inside {`OE_OFF, `OE_FOUR})
        else $error("quad read used wrong lines");
    mode_keep_a: assert property ( // RULE16
        cap && link.io[1:0] == `MODE_HOLD |=> cont_read_o)
        else $error("mode bits 10 not latched");
    mode_leave_a: assert property ( // RULE9
        (cap && link.io[1:0] != `MODE_HOLD) or (cont_read_reset_i && !cap)
        |=> !cont_read_o)
        else $error("continuous mode not left");
    cont_skip_a: assert property ( // RULE8
        state_q == ST_IDLE && link.cs_fall && cont_q && !busy_i
        |=> state_q == ST_ADDR && op_q == `OP_TWO_ADDR)
        else $error("opcode not skipped");
endmodule // serial_flash_read_engine
`default_nettype wire

// ===== test/spi_host_model.sv
// Purpose: host side of the read link, mode 0 framing
// Assumes: tasks are entered just after a clk_i edge
// Notes: released lines are scrambled by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] hio_o,
    output logic [3:0] hoe_o,
    input wire logic [3:0] io_i
);
    // ********
    // link framing
    // ********
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        hio_o = 4'h0;
        hoe_o = 4'h0;
    end

    // change on fall, sample late high
    task automatic clk1(output logic [3:0] s);
        sclk_o = 1'b0;
        #160 sclk_o = 1'b1;
        #150 s = io_i;
        #10;
    endtask

    // sync needs some clk_i cycles before first rise
    task automatic start();
        cs_n_o = 1'b0;
        #320;
    endtask

    task automatic send(input logic [31:0] v, input int n, input int ln);
        logic [3:0] s;
        hoe_o = 4'hf >> (4 - ln);
        for (int i = 0; i < n; i += ln) begin
            hio_o = v[31:28] >> (4 - ln);
            v = v << ln;
            clk1(s);
        end
    endtask

    task automatic recv(input int ln, output logic [7:0] b);
        logic [3:0] s;
        hoe_o = 4'h0;
        b = 8'h0;
        for (int i = 0; i < 8; i += ln) begin
            clk1(s);
            b = (b << ln) | 8'(ln == 1 ? s[1] : ln == 2 ? s[1:0] : s);
        end
    endtask

    task automatic stop(input int part);
        logic [3:0] s;
        for (int i = 0; i < part; i++) begin
            clk1(s);
        end
        cs_n_o = 1'b1;
        hoe_o = 4'h0;
        #160 sclk_o = 1'b0;
    endtask
endmodule // spi_host_model
`default_nettype wire

// ===== test/serial_flash_read_engine_tb.sv
// Purpose: self-checking bench of the serial flash read engine
// Assumes: link clock 320 ns, memory answers one cycle late
// Notes: memory byte is a hash of its address
`timescale 1ns/1ps
`default_nettype none
module serial_flash_read_engine_tb;
    logic clk_i, rst_n_i, busy, qe, four_line_instruction_mode, crr, cs_n, sclk, mem_rd, cont, rej;
    logic [1:0] rp;
    logic [7:0] mem_q, rcnt_q;
    logic [3:0] io_o, oe_n, hio, hoe, io_w, junk_q;
    logic [23:0] mem_a;
    logic [31:0] seed, r;
    logic [7:0] ops [5] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb};
    int miscompares, check_count;

    // ********
    // clock, wires and memory
    // ********
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // released lines toggle so a stale value never passes
    assign io_w = (~oe_n & io_o) | (oe_n & hoe & hio) | (oe_n & ~hoe & junk_q);

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            junk_q <= 4'h5;
            mem_q <= 8'h0;
            rcnt_q <= 8'h0;
        end else begin
            junk_q <= ~junk_q;
            if (mem_rd === 1'b1) mem_q <= hash(mem_a);
            if (rej === 1'b1) rcnt_q <= rcnt_q + 8'h1;
        end
    end

    serial_flash_read_engine i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .io_i(io_w), .io_o(io_o),
        .io_oe_n_o(oe_n), .busy_i(busy), .quad_enable_bit_i(qe),
        .four_line_instruction_mode_i(four_line_instruction_mode), .read_param_i(rp),
        .cont_read_reset_i(crr), .mem_data_i(mem_q), .mem_rd_o(mem_rd),
        .mem_addr_o(mem_a), .cont_read_o(cont), .reject_o(rej));

    spi_host_model i_host (.cs_n_o(cs_n), .sclk_o(sclk), .hio_o(hio),
        .hoe_o(hoe), .io_i(io_w));

    // ********
    // helpers
    // ********
    function automatic logic [7:0] hash(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
    endfunction

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input logic [31:0] seen, exp, input string nm);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one frame; lanes and dummy clocks follow the opcode
    task automatic rd(input logic [7:0] op, input logic [23:0] a,
        input int nb, input int part, input logic [7:0] md,
        input logic rj, input logic skip);
        int al, dc, dl;
        logic [7:0] b, n0;
        n0 = rcnt_q;
        al = four_line_instruction_mode ? 4 : op == 8'hbb ? 2 : 1;
        dl = four_line_instruction_mode ? 4 : op == 8'h6b ? 4 : op == 8'h03 || op == 8'h0b ? 1 : 2;
        dc = four_line_instruction_mode ? (rp == 2'h0 ? 4 : rp == 2'h1 ? 6 : 8)
            : op == 8'h03 ? 0 : op == 8'hbb ? 4 : 8;
        i_host.start();
        if (!skip) i_host.send({op, 24'h0}, 8, four_line_instruction_mode ? 4 : 1);
        i_host.send({a, 8'h0}, 24, al);
        // mode byte rides in the dummy clocks
        if (dc > 0) i_host.send({md, 24'h0}, dc * al, al);
        chk(oe_n, 4'hf, "oe header");
        for (int i = 0; i < nb; i++) begin
            i_host.recv(dl, b);
            if (!rj) chk(b, hash(a + 24'(i)), "data");
        end
        if (!rj) begin
            chk(oe_n, dl == 1 ? 4'hd : dl == 2 ? 4'hc : 4'h0, "oe");
        end
        i_host.stop(part);
        tick(6);
        chk(oe_n, 4'hf, "oe stop");
        chk(8'(rcnt_q - n0), {7'h0, rj}, "reject");
    endtask

    // ********
    // main sequence
    // ********
    initial begin
        rst_n_i = 1'b0;
        busy = 1'b0;
        qe = 1'b1;
        four_line_instruction_mode = 1'b0;
        rp = 2'h0;
        crr = 1'b0;
        seed = 32'h0000c7a3;
        miscompares = 0;
        check_count = 0;
        tick(20);
        rst_n_i = 1'b1;
        tick(4);
        chk({oe_n, cont, mem_rd, rej}, 7'h78, "reset outs");
        chk(mem_a, 24'h0, "reset addr");
        for (int k = 0; k < 10; k++) begin
            r = rnd();
            // every opcode twice, the rest random
            rd(ops[k % 5], r[31:8], 1 + r[4:3], r[7:5], 8'h0, 1'b0, 1'b0);
        end
        rd(8'h03, 24'hffffff, 2, 0, 8'h00, 1'b0, 1'b0);
        // one fetch ahead: third byte already asked for
        chk(mem_a, 24'h000002, "wrap addr");
        // busy refuses all but the plain read
        busy = 1'b1;
        for (int k = 1; k < 5; k++) begin
            rd(ops[k], 24'h000100, 1, 0, 8'h00, 1'b1, 1'b0);
        end
        rd(8'h03, 24'h000100, 1, 0, 8'h00, 1'b0, 1'b0);
        busy = 1'b0;
        rd(8'h5a, 24'h000100, 1, 0, 8'h00, 1'b1, 1'b0);
        qe = 1'b0;
        rd(8'h6b, 24'h00abcd, 1, 0, 8'h00, 1'b1, 1'b0);
        // host sets quad enable before quad reads
        qe = 1'b1;
        rd(8'hbb, 24'h123456, 1, 3, 8'h20, 1'b0, 1'b0);
        chk(cont, 1'b1, "cont armed");
        rd(8'hbb, 24'h654321, 2, 0, 8'h00, 1'b0, 1'b1);
        chk(cont, 1'b0, "cont left");
        rd(8'hbb, 24'h000010, 1, 0, 8'h20, 1'b0, 1'b0);
        crr = 1'b1;
        tick(1);
        crr = 1'b0;
        chk(cont, 1'b0, "cont reset");
        rd(8'h03, 24'h000020, 1, 0, 8'h00, 1'b0, 1'b0);
        // four-line fast read, dummy by parameter
        four_line_instruction_mode = 1'b1;
        for (int p = 0; p < 4; p++) begin
            rp = 2'(p);
            rd(8'h0b, 24'(rnd()), 2, 0, 8'h00, 1'b0, 1'b0);
        end
        // busy refuses the four-line read too
        busy = 1'b1;
        rd(8'h0b, 24'h000100, 1, 0, 8'h00, 1'b1, 1'b0);
        busy = 1'b0;
        four_line_instruction_mode = 1'b0;
        results();
    end

    // hang guard well beyond the longest run
    initial begin
        #4000000;
        miscompares++;
        results();
    end
endmodule // serial_flash_read_engine_tb
`default_nettype wire
